// ### cspr_addr_modify.v
// Purpose: Data memory address modification by index and row pointer
// Assumes: Data address is bank[10:7], row[6:4], column[3:0]
// Notes:   Purely combinational; sits in the address path of the core
`timescale 1ns/10ps
`default_nettype none

module cspr_addr_modify (
  input wire [10:0] data_index_offset,
  input wire index_modify_enable,
  input wire [6:0] row_pointer,
  input wire row_pointer_enable,
  input wire [10:0] dm_addr_in,
  input wire [10:0] ind_addr_in,
  output wire [10:0] dm_addr_out,
  output wire [10:0] ind_addr_out
);

  // ----------------------------------------------------------------
  // Index modification: bank, row and column ORed with the index
  // ----------------------------------------------------------------
  assign dm_addr_out = index_modify_enable ?
                       (dm_addr_in | data_index_offset) : dm_addr_in;

  // ----------------------------------------------------------------
  // Row pointer replaces bank and row of indirect transfer target
  // ----------------------------------------------------------------
  assign ind_addr_out = row_pointer_enable ?
                        {row_pointer, ind_addr_in[3:0]} : ind_addr_in;

endmodule // cspr_addr_modify

`default_nettype wire

// ### cspr_core.v
// Purpose: CPU system pointer registers: program address pointer, window,
//          bank selector, index offset and row pointer, on classic Wishbone
// Assumes: Single clock; core strobes are one-cycle pulses synchronous to clk
// Notes:   Resets other than rst_n arrive as synchronous one-cycle pulses
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "cspr_defs.vh"

module cspr_core (
  input wire clk,
  input wire rst_n,
  input wire watchdog_stack_reset,
  input wire chip_enable_reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [8:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire pointer_increment_op,
  input wire data_buffer_path_load,
  input wire [15:0] data_buffer_path_in,
  output wire [15:0] data_buffer_path_out,
  input wire file_read_op,
  input wire file_write_op,
  input wire [6:0] file_addr,
  input wire [3:0] peripheral_control_file_rdata,
  output reg pcf_write_strobe,
  output reg [6:0] pcf_addr,
  output reg [3:0] pcf_wdata,
  output wire [15:0] program_address_pointer,
  output wire [3:0] file_window_nibble,
  output wire [3:0] bank_select,
  output wire [10:0] data_index_offset,
  output wire [6:0] row_pointer,
  output wire index_modify_enable,
  output wire row_pointer_enable,
  input wire [10:0] dm_addr_in,
  input wire [10:0] ind_addr_in,
  output wire [10:0] dm_addr_out,
  output wire [10:0] ind_addr_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [15:0] ptr_q;
  reg [15:0] ptr_d;
  reg [3:0] window_q;
  reg [3:0] window_d;
  reg [3:0] bank_q;
  reg [3:0] bank_d;
  reg [2:0] ix_high_q;
  reg [2:0] ix_high_d;
  reg mpe_q;
  reg mpe_d;
  reg [3:0] ix_mid_q;
  reg [3:0] ix_mid_d;
  reg [3:0] ix_low_q;
  reg [3:0] ix_low_d;
  reg ixe_q;
  reg ixe_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [6:0] reg_idx;
  wire bus_req;
  wire bus_wr;
  wire soft_reset;
  reg [3:0] rd_nib;
  reg rd_hit;

  assign reg_idx = wb_adr_i[8:2];
  assign bus_req = wb_cyc_i & wb_stb_i;
  // Write lands on the edge where ack is seen high by the master
  assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
  assign soft_reset = watchdog_stack_reset | chip_enable_reset;

  always @* begin
    rd_hit = 1'b1;
    rd_nib = 4'h0;
    if (reg_idx == `CSPR_IDX_PTR3) begin
      rd_nib = ptr_q[15:12];
    end else if (reg_idx == `CSPR_IDX_PTR2) begin
      rd_nib = ptr_q[11:8];
    end else if (reg_idx == `CSPR_IDX_PTR1) begin
      rd_nib = ptr_q[7:4];
    end else if (reg_idx == `CSPR_IDX_PTR0) begin
      rd_nib = ptr_q[3:0];
    end else if (reg_idx == `CSPR_IDX_WINDOW) begin
      rd_nib = window_q;
    end else if (reg_idx == `CSPR_IDX_BANK) begin
      rd_nib = bank_q;
    end else if (reg_idx == `CSPR_IDX_IXHIGH) begin
      rd_nib = {mpe_q, ix_high_q};
    end else if (reg_idx == `CSPR_IDX_IXMID) begin
      rd_nib = ix_mid_q;
    end else if (reg_idx == `CSPR_IDX_IXLOW) begin
      rd_nib = ix_low_q;
    end else if (reg_idx == `CSPR_IDX_STATUS) begin
      // Only the index enable lives here; other flags belong elsewhere
      rd_nib = {3'b000, ixe_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer: one wait state, ack for one cycle
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & ~wb_ack_o;
      // Unmapped indices still ack and read as zero so the bus never hangs
      if (bus_req & ~wb_ack_o & ~wb_we_i & rd_hit) begin
        wb_dat_o <= {28'h000_0000, rd_nib};
      end else begin
        wb_dat_o <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // Program address pointer
  // ----------------------------------------------------------------
  always @* begin
    ptr_d = ptr_q;
    if (data_buffer_path_load) begin
      ptr_d = data_buffer_path_in;
    end else if (bus_wr && reg_idx == `CSPR_IDX_PTR3) begin
      ptr_d[15:12] = wb_dat_i[3:0];
    end else if (bus_wr && reg_idx == `CSPR_IDX_PTR2) begin
      ptr_d[11:8] = wb_dat_i[3:0];
    end else if (bus_wr && reg_idx == `CSPR_IDX_PTR1) begin
      ptr_d[7:4] = wb_dat_i[3:0];
    end else if (bus_wr && reg_idx == `CSPR_IDX_PTR0) begin
      ptr_d[3:0] = wb_dat_i[3:0];
    end else if (pointer_increment_op) begin
      // All ones rolls to zero; no carry is reported anywhere
      ptr_d = ptr_q + `CSPR_PTR_ONE;
    end
  end

  // Full 16 bits are kept; the top of program memory is software's concern
  always @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      ptr_q <= `CSPR_PTR_RST;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign data_buffer_path_out = ptr_q;
  assign program_address_pointer = ptr_q;

  // ----------------------------------------------------------------
  // Window register and control file transfers
  // ----------------------------------------------------------------
  always @* begin
    window_d = window_q;
    if (file_read_op) begin
      window_d = peripheral_control_file_rdata;
    end else if (bus_wr && reg_idx == `CSPR_IDX_WINDOW) begin
      window_d = wb_dat_i[3:0];
    end
  end

  // Power-on value is arbitrary by nature; zero is used for clean simulation.
  // The other resets deliberately leave the window alone.
  always @(posedge clk) begin
    if (!rst_n) begin
      window_q <= `CSPR_WINDOW_RST;
    end else begin
      window_q <= window_d;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pcf_write_strobe <= 1'b0;
      pcf_addr <= 7'h00;
      pcf_wdata <= 4'h0;
    end else begin
      pcf_write_strobe <= file_write_op;
      if (file_write_op) begin
        pcf_addr <= file_addr;
        pcf_wdata <= window_q;
      end
    end
  end

  assign file_window_nibble = window_q;

  // ----------------------------------------------------------------
  // Bank selector
  // ----------------------------------------------------------------
  always @* begin
    bank_d = bank_q;
    // System area: no bank qualifier on this decode
    if (bus_wr && reg_idx == `CSPR_IDX_BANK) begin
      bank_d = wb_dat_i[3:0];
    end
  end

  always @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      bank_q <= `CSPR_BANK_RST;
    end else begin
      bank_q <= bank_d;
    end
  end

  // Unimplemented banks are not trapped; value passes straight through
  assign bank_select = bank_q;

  // ----------------------------------------------------------------
  // Index offset and row pointer (shared upper storage)
  // ----------------------------------------------------------------
  always @* begin
    ix_high_d = ix_high_q;
    mpe_d = mpe_q;
    ix_mid_d = ix_mid_q;
    ix_low_d = ix_low_q;
    ixe_d = ixe_q;
    if (bus_wr && reg_idx == `CSPR_IDX_IXHIGH) begin
      ix_high_d = wb_dat_i[2:0];
      mpe_d = wb_dat_i[`CSPR_HIGH_MPE_BIT];
    end else if (bus_wr && reg_idx == `CSPR_IDX_IXMID) begin
      ix_mid_d = wb_dat_i[3:0];
    end else if (bus_wr && reg_idx == `CSPR_IDX_IXLOW) begin
      ix_low_d = wb_dat_i[3:0];
    end else if (bus_wr && reg_idx == `CSPR_IDX_STATUS) begin
      ixe_d = wb_dat_i[`CSPR_STATUS_IXE_BIT];
    end
  end

  always @(posedge clk) begin
    if (!rst_n || soft_reset) begin
      ix_high_q <= 3'b000;
      mpe_q <= `CSPR_FLAG_RST;
      ix_mid_q <= `CSPR_NIB_RST;
      ix_low_q <= `CSPR_NIB_RST;
      ixe_q <= `CSPR_FLAG_RST;
    end else begin
      ix_high_q <= ix_high_d;
      mpe_q <= mpe_d;
      ix_mid_q <= ix_mid_d;
      ix_low_q <= ix_low_d;
      ixe_q <= ixe_d;
    end
  end

  // One set of flops feeds both views, so a write to the high or middle nibble moves both
  assign data_index_offset = {ix_high_q, ix_mid_q, ix_low_q};
  assign row_pointer = {ix_high_q, ix_mid_q};
  assign index_modify_enable = ixe_q;
  assign row_pointer_enable = mpe_q;

  // ----------------------------------------------------------------
  // Address modification path
  // ----------------------------------------------------------------
  cspr_addr_modify u_addr_modify (
    .data_index_offset(data_index_offset),
    .index_modify_enable(ixe_q),
    .row_pointer(row_pointer),
    .row_pointer_enable(mpe_q),
    .dm_addr_in(dm_addr_in),
    .ind_addr_in(ind_addr_in),
    .dm_addr_out(dm_addr_out),
    .ind_addr_out(ind_addr_out)
  );

endmodule // cspr_core

`default_nettype wire

// ### cspr_core_sva.sv
// Purpose: Port-level checks for the CPU system pointer registers
// Assumes: Single clock, rst_n synchronous active low
// Notes:   Bus writes are excluded where they could mask a strobe effect
`timescale 1ns/10ps
`default_nettype none

module cspr_core_sva (
  input wire clk,
  input wire rst_n,
  input wire watchdog_stack_reset,
  input wire chip_enable_reset,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire pointer_increment_op,
  input wire data_buffer_path_load,
  input wire [15:0] data_buffer_path_in,
  input wire [15:0] data_buffer_path_out,
  input wire [15:0] program_address_pointer,
  input wire file_read_op,
  input wire [3:0] peripheral_control_file_rdata,
  input wire [3:0] file_window_nibble,
  input wire file_write_op,
  input wire [6:0] file_addr,
  input wire pcf_write_strobe,
  input wire [6:0] pcf_addr,
  input wire [3:0] pcf_wdata,
  input wire [3:0] bank_select,
  input wire [10:0] data_index_offset,
  input wire [6:0] row_pointer,
  input wire index_modify_enable,
  input wire row_pointer_enable,
  input wire [10:0] dm_addr_in,
  input wire [10:0] dm_addr_out
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire no_rst = !watchdog_stack_reset && !chip_enable_reset;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  // Bus write may land on the same edge, so only quiet cycles are judged
  property p_inc;
    pointer_increment_op && !data_buffer_path_load && !wb_ack_o && no_rst
      |=> program_address_pointer == $past(program_address_pointer) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");
  property p_load;
    data_buffer_path_load && no_rst |=> program_address_pointer == $past(data_buffer_path_in);
  endproperty
  a_load: assert property (p_load) else $error("pointer load wrong");
  property p_dbf; data_buffer_path_out == program_address_pointer; endproperty
  a_dbf: assert property (p_dbf) else $error("pointer readout differs");
  property p_file_read_op; file_read_op |=> file_window_nibble == $past(peripheral_control_file_rdata);
  endproperty
  a_file_read_op: assert property (p_file_read_op) else $error("file read wrong");
  property p_file_write_op;
    file_write_op |=> pcf_write_strobe && pcf_addr == $past(file_addr)
      && pcf_wdata == $past(file_window_nibble);
  endproperty
  a_file_write_op: assert property (p_file_write_op) else $error("file write wrong");
  property p_clr;
    !no_rst |=> bank_select == 4'h0 && data_index_offset == 11'h000
      && !index_modify_enable && !row_pointer_enable;
  endproperty
  a_clr: assert property (p_clr) else $error("soft reset not clearing");
  property p_share; row_pointer == data_index_offset[10:4]; endproperty
  a_share: assert property (p_share) else $error("row pointer not shared");
  property p_ixmod;
    dm_addr_out == (index_modify_enable ? (dm_addr_in | data_index_offset) : dm_addr_in);
  endproperty
  a_ixmod: assert property (p_ixmod) else $error("index modify wrong");
  c_wrap: cover property (pointer_increment_op && program_address_pointer == 16'hffff);
  c_file_write_op: cover property (file_write_op);
  c_soft: cover property (watchdog_stack_reset);
endmodule // cspr_core_sva

bind cspr_core cspr_core_sva cspr_core_sva_inst (.*);

`default_nettype wire

// ### cspr_core_tb_top.sv
// Purpose: Directed bench for the CPU system pointer registers
// Assumes: Bus answer one cycle after request, strobes act at their edge
// Notes:   Window reset value 0 is a design choice
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end

module cspr_core_tb_top;
  logic clk = 1'h0, rst_n = 1'h0, watchdog_stack_reset = 1'h0, chip_enable_reset = 1'h0;
  logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, pcf_write_strobe;
  logic pointer_increment_op = 1'h0, data_buffer_path_load = 1'h0;
  logic file_read_op = 1'h0, file_write_op = 1'h0, index_modify_enable, row_pointer_enable;
  logic [8:0] wb_adr_i = 9'h000;
  logic [3:0] wb_sel_i = 4'h0, peripheral_control_file_rdata = 4'h0, q;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [15:0] data_buffer_path_in = 16'h0000, data_buffer_path_out, program_address_pointer;
  logic [6:0] file_addr = 7'h00, pcf_addr, row_pointer;
  logic [3:0] pcf_wdata, file_window_nibble, bank_select;
  logic [10:0] data_index_offset, dm_addr_in = 11'h000, ind_addr_in = 11'h000;
  logic [10:0] dm_addr_out, ind_addr_out;
  int num_errors = 0, tests_run = 0;

  cspr_core cspr_core_inst (.*);

  initial begin
    forever #5 clk = ~clk;
  end

  task stop_test;
    $display("COUNTS compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----
  // Bus and strobe helpers
  // ----
  task wb(input logic we, input logic [6:0] idx, input logic [3:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= 4'h1;
    wb_dat_i <= {28'h000_0000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 20);
    // A lost answer would hang every later test, so give up here
    if (n >= 20) begin
      num_errors++;
      stop_test();
    end else begin
      q = wb_dat_o[3:0];
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
      wb_we_i <= 1'h0;
      // Write lands on the ack edge; let it settle before callers look
      @(posedge clk);
    end
  endtask

  task settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  task t_reset;
    for (int i = 0; i < 11; i++) begin
      wb(1'h0, (i < 9) ? 7'(7'h74 + i) : ((i == 9) ? 7'h7f : 7'h70), 4'h0);
      `CHK(q, 4'h0)
    end
    $display("done reset values");
  endtask

  task t_ptr;
    // Value stays inside the smallest program memory
    for (int i = 0; i < 4; i++) wb(1'h1, 7'(7'h74 + i), 4'(i + 1));
    `CHK(program_address_pointer, 16'h1234)
    @(posedge clk);
    data_buffer_path_in <= 16'hffff;
    data_buffer_path_load <= 1'h1;
    @(posedge clk);
    data_buffer_path_load <= 1'h0;
    pointer_increment_op <= 1'h1;
    @(negedge clk);
    `CHK(data_buffer_path_out, 16'hffff)
    settle();
    `CHK(program_address_pointer, 16'h0000)
    @(posedge clk);
    pointer_increment_op <= 1'h0;
    @(negedge clk);
    `CHK(program_address_pointer, 16'h0001)
    wb(1'h0, 7'h77, 4'h0);
    `CHK(q, 4'h1)
    $display("done pointer");
  endtask

  task t_win;
    @(posedge clk);
    peripheral_control_file_rdata <= 4'ha;
    file_read_op <= 1'h1;
    @(posedge clk);
    file_read_op <= 1'h0;
    wb(1'h0, 7'h78, 4'h0);
    `CHK(q, 4'ha)
    wb(1'h1, 7'h78, 4'h5);
    @(posedge clk);
    file_addr <= 7'h2c;
    file_write_op <= 1'h1;
    @(posedge clk);
    file_write_op <= 1'h0;
    @(negedge clk);
    `CHK({pcf_write_strobe, pcf_addr, pcf_wdata}, {1'h1, 7'h2c, 4'h5})
    @(negedge clk);
    `CHK(pcf_write_strobe, 1'h0)
    $display("done window");
  endtask

  task t_bank;
    // Full-size variant assumed, so every bank exists
    for (int b = 0; b < 16; b++) begin
      wb(1'h1, 7'h79, 4'(b));
      `CHK(bank_select, 4'(b))
      wb(1'h0, 7'h79, 4'h0);
      `CHK(q, 4'(b))
    end
    @(posedge clk);
    watchdog_stack_reset <= 1'h1;
    @(posedge clk);
    watchdog_stack_reset <= 1'h0;
    @(negedge clk);
    `CHK({bank_select, file_window_nibble}, 8'h05)
    $display("done bank");
  endtask

  task t_idx;
    wb(1'h1, 7'h7a, 4'hd);
    wb(1'h1, 7'h7b, 4'h6);
    wb(1'h1, 7'h7c, 4'h9);
    wb(1'h1, 7'h7f, 4'h1);
    dm_addr_in <= 11'h002;
    ind_addr_in <= 11'h00f;
    settle();
    `CHK({index_modify_enable, row_pointer_enable}, 2'h3)
    `CHK(data_index_offset, 11'h569)
    `CHK(row_pointer, 7'h56)
    `CHK(dm_addr_out, 11'h56b)
    `CHK(ind_addr_out, 11'h56f)
    wb(1'h1, 7'h7b, 4'h3);
    `CHK(data_index_offset, 11'h539)
    @(posedge clk);
    chip_enable_reset <= 1'h1;
    @(posedge clk);
    chip_enable_reset <= 1'h0;
    @(negedge clk);
    `CHK(data_index_offset, 11'h000)
    `CHK({dm_addr_out, ind_addr_out}, {11'h002, 11'h00f})
    $display("done index");
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_ptr();
    t_win();
    t_bank();
    t_idx();
    stop_test();
  end

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end
endmodule // cspr_core_tb_top

`default_nettype wire

// ### cspr_defs.vh
// Purpose: Shared constants for the CPU system pointer register group
// Assumes: Register indices are nibble system addresses; byte address = 4 * index
// Notes:   Included by bare name from the core design file only
`ifndef CSPR_DEFS_VH
`define CSPR_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------------------------------
`define CSPR_IDX_PTR3 7'h74
`define CSPR_IDX_PTR2 7'h75
`define CSPR_IDX_PTR1 7'h76
`define CSPR_IDX_PTR0 7'h77
`define CSPR_IDX_WINDOW 7'h78
`define CSPR_IDX_BANK 7'h79
`define CSPR_IDX_IXHIGH 7'h7a
`define CSPR_IDX_IXMID 7'h7b
`define CSPR_IDX_IXLOW 7'h7c
`define CSPR_IDX_STATUS 7'h7f

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSPR_HIGH_MPE_BIT 3
`define CSPR_STATUS_IXE_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSPR_PTR_RST 16'h0000
`define CSPR_WINDOW_RST 4'h0
`define CSPR_BANK_RST 4'h0
`define CSPR_NIB_RST 4'h0
`define CSPR_FLAG_RST 1'b0
`define CSPR_PTR_ONE 16'h0001

`endif
